/* design/jls_link_setup.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - mode register picks full band or two converters
// - decimation code sets output sample rate
// - serializer pll state readable after power-up
// - lane register sets scrambling and lane count
// - converter count register sets two or four
// - octet register sets one or four octets
// - downconverter gain, ratio nibble and channel select
// - subclass field resets to one, zero selects zero
// - subclass zero runs with sysref ignored
// - subclass one sysref aligns lmfc and dividers
// - lmfc boundary marks every multiframe start
// - offset field delays lmfc in frame steps
// - offset step depends on octets per frame
// - transition select picks rising or falling sysref
// - clock edge select picks sysref capture edge
// - status shows likely sysref setup or hold miss
module jls_link_setup
   import jls_pkg::*;
#(
   parameter int FRAMES_PER_MF_P = FRAMES_PER_MF,
   parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input wire logic sysref,
   output logic lmfc_pulse,
   output logic sample_strobe,
   output logic sysref_aligned,
   output logic full_bandwidth,
   output logic two_downconverter,
   output logic link_enable,
   output logic scramble_en,
   output logic [4:0] lane_count,
   output logic [7:0] converter_count,
   output logic [7:0] octets_per_frame,
   output logic [2:0] subclass,
   output logic [7:0] pll_select,
   output logic downconverter_zero_gain_6db,
   output logic [3:0] downconverter_zero_ratio,
   output logic downconverter_zero_src_b,
   output logic downconverter_one_gain_6db,
   output logic [3:0] downconverter_one_ratio,
   output logic downconverter_one_src_b
);
   localparam int CW = $clog2(FRAMES_PER_MF_P);
   localparam logic [CW-1:0] LMFC_LAST = CW'(FRAMES_PER_MF_P - 1);

   function automatic logic [3:0] dec_ratio(input logic [7:0] code);
      logic [3:0] r;
      r = DEC_RATIO_1;
      if (code == DEC_CODE_10) begin
         r = DEC_RATIO_10;
      end
      return r;
   endfunction

   // shift is in frames; invalid low bits for small F are dropped
   function automatic logic [4:0] ofs_shift(input logic [7:0] ofs, input logic [7:0] octets);
      logic [4:0] s;
      s = ofs[OFS_MSB:0];
      if (octets == 8'h00) begin
         s = {ofs[OFS_MSB:2], 2'b00};
      end else if (octets == 8'h01) begin
         s = {ofs[OFS_MSB:1], 1'b0};
      end
      return s;
   endfunction

   // ---------------- serial control port ----------------
   logic sclk_q_ff, rd_mode_ff, sdo_ff, sdo_oe_n_ff;
   logic sclk_rise, sclk_fall, wr_pulse;
   logic [4:0] bit_cnt_ff;
   logic [22:0] shin_ff;
   logic [7:0] rd_sh_ff, wr_data, rd_data;
   logic [14:0] wr_addr, rd_addr;

   assign sclk_rise = spi_sclk & ~sclk_q_ff;
   assign sclk_fall = ~spi_sclk & sclk_q_ff;
   assign wr_pulse = ~spi_cs_n & sclk_rise & (bit_cnt_ff == 5'(SPI_FRAME_BITS - 1)) & ~shin_ff[22];
   assign wr_addr = shin_ff[21:7];
   assign wr_data = {shin_ff[6:0], spi_sdi};
   assign rd_addr = {shin_ff[13:0], spi_sdi};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclk_q_ff <= 1'b0;
      end else begin
         sclk_q_ff <= spi_sclk;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || spi_cs_n) begin
         bit_cnt_ff <= 5'h00;
         shin_ff <= 23'h000000;
      end else if (sclk_rise) begin
         shin_ff <= {shin_ff[21:0], spi_sdi};
         if (bit_cnt_ff != 5'(SPI_FRAME_BITS - 1)) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
         end else begin
            bit_cnt_ff <= 5'h00;
         end
      end
   end

   // one byte per frame; read data is latched once the address is in
   always_ff @(posedge ref_clk) begin
      if (rst || spi_cs_n) begin
         rd_mode_ff <= 1'b0;
         rd_sh_ff <= 8'h00;
         sdo_ff <= 1'b0;
         sdo_oe_n_ff <= 1'b1;
      end else if (sclk_rise && bit_cnt_ff == 5'(SPI_INSTR_BITS - 1)) begin
         rd_mode_ff <= shin_ff[14];
         rd_sh_ff <= rd_data;
      end else if (sclk_fall && rd_mode_ff) begin
         sdo_ff <= rd_sh_ff[7];
         rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
         sdo_oe_n_ff <= 1'b0;
      end else if (sclk_rise && bit_cnt_ff == 5'(SPI_FRAME_BITS - 1)) begin
         rd_mode_ff <= 1'b0;
      end
   end

   assign spi_sdo = sdo_ff;
   assign spi_sdo_oe_n = sdo_oe_n_ff;

   // ---------------- configuration registers ----------------
   logic [7:0] sr_ctrl_ff, app_mode_ff, chip_dec_ff, dc0_ctrl_ff, dc0_src_ff;
   logic [7:0] dc1_ctrl_ff, dc1_src_ff, pll_ctrl_ff, link_pwr_ff, lmfc_ofs_ff;
   logic [7:0] lane_cfg_ff, octets_ff, conv_ff, subclass_ff;
   logic [7:0] step_a_ff, step_b_ff, step_c_ff;
   logic [7:0] sr_stat_ff;
   logic pll_lock_ff;
   logic soft_reset;

   assign soft_reset = wr_pulse && wr_addr == ADDR_SOFT_RESET && wr_data == SOFT_RESET_CMD;

   always_ff @(posedge ref_clk) begin
      if (rst || soft_reset) begin
         sr_ctrl_ff <= RST_ZERO;
         app_mode_ff <= APP_FULL_BW;
         chip_dec_ff <= DEC_CODE_1;
         dc0_ctrl_ff <= RST_ZERO;
         dc0_src_ff <= RST_ZERO;
         dc1_ctrl_ff <= RST_ZERO;
         dc1_src_ff <= RST_ZERO;
         pll_ctrl_ff <= RST_ZERO;
         link_pwr_ff <= RST_LINK_PWR;
         lmfc_ofs_ff <= RST_ZERO;
         lane_cfg_ff <= RST_ZERO;
         octets_ff <= RST_ZERO;
         conv_ff <= RST_ZERO;
         subclass_ff <= RST_SUBCLASS;
         step_a_ff <= RST_ZERO;
         step_b_ff <= RST_ZERO;
         step_c_ff <= RST_ZERO;
      end else if (wr_pulse) begin
         unique case (wr_addr)
            ADDR_SYSREF_CTRL: sr_ctrl_ff <= wr_data;
            ADDR_APP_MODE: app_mode_ff <= wr_data;
            ADDR_CHIP_DEC: chip_dec_ff <= wr_data;
            ADDR_DC0_CTRL: dc0_ctrl_ff <= wr_data;
            ADDR_DC0_SRC: dc0_src_ff <= wr_data;
            ADDR_DC1_CTRL: dc1_ctrl_ff <= wr_data;
            ADDR_DC1_SRC: dc1_src_ff <= wr_data;
            ADDR_PLL_CTRL: pll_ctrl_ff <= wr_data;
            ADDR_LINK_PWR: link_pwr_ff <= wr_data;
            ADDR_LMFC_OFS: lmfc_ofs_ff <= {3'b000, wr_data[OFS_MSB:0]};
            ADDR_LANE_CFG: lane_cfg_ff <= wr_data;
            ADDR_OCTETS: octets_ff <= wr_data;
            ADDR_CONV: conv_ff <= wr_data;
            ADDR_SUBCLASS: subclass_ff <= {wr_data[SUBCLASS_MSB:SUBCLASS_LSB], 5'h00};
            ADDR_STEP_A: step_a_ff <= wr_data;
            ADDR_STEP_B: step_b_ff <= wr_data;
            ADDR_STEP_C: step_c_ff <= wr_data;
            default: ;
         endcase
      end
   end

   // unmapped addresses and the self-clearing reset byte read as zero
   always_comb begin
      rd_data = 8'h00;
      unique case (rd_addr)
         ADDR_SYSREF_CTRL: rd_data = sr_ctrl_ff;
         ADDR_SYSREF_STAT: rd_data = sr_stat_ff;
         ADDR_APP_MODE: rd_data = app_mode_ff;
         ADDR_CHIP_DEC: rd_data = chip_dec_ff;
         ADDR_DC0_CTRL: rd_data = dc0_ctrl_ff;
         ADDR_DC0_SRC: rd_data = dc0_src_ff;
         ADDR_DC1_CTRL: rd_data = dc1_ctrl_ff;
         ADDR_DC1_SRC: rd_data = dc1_src_ff;
         ADDR_PLL_CTRL: rd_data = pll_ctrl_ff;
         ADDR_PLL_STAT: rd_data = {pll_lock_ff, 7'h00};
         ADDR_LINK_PWR: rd_data = link_pwr_ff;
         ADDR_LMFC_OFS: rd_data = lmfc_ofs_ff;
         ADDR_LANE_CFG: rd_data = lane_cfg_ff;
         ADDR_OCTETS: rd_data = octets_ff;
         ADDR_CONV: rd_data = conv_ff;
         ADDR_SUBCLASS: rd_data = subclass_ff;
         ADDR_STEP_A: rd_data = step_a_ff;
         ADDR_STEP_B: rd_data = step_b_ff;
         ADDR_STEP_C: rd_data = step_c_ff;
         default: rd_data = 8'h00;
      endcase
   end

   assign full_bandwidth = (app_mode_ff == APP_FULL_BW);
   assign two_downconverter = (app_mode_ff == APP_TWO_DC);
   assign link_enable = ~link_pwr_ff[PWR_DOWN_BIT];
   assign scramble_en = lane_cfg_ff[LANE_SCR_BIT];
   assign lane_count = lane_cfg_ff[LANE_CNT_MSB:0] + 5'h01;
   assign converter_count = conv_ff + 8'h01;
   assign octets_per_frame = octets_ff + 8'h01;
   assign subclass = subclass_ff[SUBCLASS_MSB:SUBCLASS_LSB];
   assign pll_select = pll_ctrl_ff;
   assign downconverter_zero_gain_6db = dc0_ctrl_ff[DC_GAIN_BIT];
   assign downconverter_zero_ratio = dc0_src_ff[7:4];
   assign downconverter_zero_src_b = dc0_src_ff[DC_SRC_BIT];
   assign downconverter_one_gain_6db = dc1_ctrl_ff[DC_GAIN_BIT];
   assign downconverter_one_ratio = dc1_src_ff[7:4];
   assign downconverter_one_src_b = dc1_src_ff[DC_SRC_BIT];

   // ---------------- serializer pll lock ----------------
   logic [31:0] pll_cnt_ff;

   always_ff @(posedge ref_clk) begin
      if (rst || !link_enable) begin
         pll_cnt_ff <= 32'h00000000;
         pll_lock_ff <= 1'b0;
      end else if (pll_cnt_ff == 32'(PLL_LOCK_CYCLES - 1)) begin
         pll_lock_ff <= 1'b1;
      end else begin
         pll_cnt_ff <= pll_cnt_ff + 32'h00000001;
      end
   end

   // ---------------- sysref capture ----------------
   logic sr_neg_ff, sr_pos_ff, sr_prev_ff;
   logic sr_sel, sr_event, sc1_active;

   always_ff @(negedge ref_clk) begin
      if (rst) begin
         sr_neg_ff <= 1'b0;
      end else begin
         sr_neg_ff <= sysref;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sr_pos_ff <= 1'b0;
         sr_prev_ff <= 1'b0;
      end else begin
         sr_pos_ff <= sysref;
         sr_prev_ff <= sr_sel;
      end
   end

   assign sr_sel = sr_ctrl_ff[SR_CLKEDGE_BIT] ? sr_neg_ff : sr_pos_ff;
   assign sr_event = sr_ctrl_ff[SR_TRANS_BIT] ? (sr_prev_ff & ~sr_sel) : (~sr_prev_ff & sr_sel);
   // subclass zero ignores the pin so a floating sysref is harmless
   assign sc1_active = (subclass != 3'h0) && link_enable;

   // a change within half a period of the rising ref_clk edge is flagged, whichever capture edge is selected
   always_ff @(posedge ref_clk) begin
      if (rst || soft_reset) begin
         sr_stat_ff <= 8'h00;
      end else begin
         if (sysref != sr_neg_ff) begin
            sr_stat_ff[STAT_SETUP_BIT] <= 1'b1;
         end
         if (sr_neg_ff != sr_pos_ff) begin
            sr_stat_ff[STAT_HOLD_BIT] <= 1'b1;
         end
      end
   end

   // ---------------- lmfc and sample divider ----------------
   logic [CW-1:0] lmfc_cnt_ff, nxt_lmfc_cnt;
   logic [4:0] shift_ff;
   logic [3:0] div_cnt_ff, cur_ratio;
   logic lmfc_pulse_ff, sample_strobe_ff, aligned_ff;

   assign cur_ratio = dec_ratio(chip_dec_ff);

   always_comb begin
      nxt_lmfc_cnt = lmfc_cnt_ff + CW'(1);
      if (sr_event && sc1_active) begin
         nxt_lmfc_cnt = '0;
      end else if (lmfc_cnt_ff == LMFC_LAST) begin
         nxt_lmfc_cnt = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lmfc_cnt_ff <= '0;
         shift_ff <= 5'h00;
         lmfc_pulse_ff <= 1'b0;
      end else begin
         lmfc_cnt_ff <= nxt_lmfc_cnt;
         shift_ff <= ofs_shift(lmfc_ofs_ff, octets_ff);
         // registered shift costs one cycle of latency after an offset write
         lmfc_pulse_ff <= (nxt_lmfc_cnt == CW'(shift_ff));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_cnt_ff <= 4'h0;
         sample_strobe_ff <= 1'b0;
      end else if ((sr_event && sc1_active) || div_cnt_ff >= cur_ratio - 4'h1) begin
         div_cnt_ff <= 4'h0;
         sample_strobe_ff <= 1'b1;
      end else begin
         div_cnt_ff <= div_cnt_ff + 4'h1;
         sample_strobe_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aligned_ff <= 1'b0;
      end else begin
         aligned_ff <= sr_event && sc1_active;
      end
   end

   assign lmfc_pulse = lmfc_pulse_ff;
   assign sample_strobe = sample_strobe_ff;
   assign sysref_aligned = aligned_ff;

   // ---------------- checks ----------------
   property p_sc1_align;
      @(posedge ref_clk) disable iff (rst)
      (sr_event && sc1_active) |=> (lmfc_cnt_ff == '0) && aligned_ff && div_cnt_ff == 4'h0;
   endproperty
   a_sc1_align: assert property (p_sc1_align) else $error("lmfc not aligned by sysref");
   property p_sc0_free;
      @(posedge ref_clk) disable iff (rst)
      (subclass == 3'h0 && lmfc_cnt_ff != LMFC_LAST) |=> lmfc_cnt_ff == $past(lmfc_cnt_ff) + CW'(1);
   endproperty
   a_sc0_free: assert property (p_sc0_free) else $error("subclass 0 lmfc disturbed");
   property p_boundary;
      @(posedge ref_clk) disable iff (rst)
      lmfc_pulse_ff |-> lmfc_cnt_ff == CW'($past(shift_ff));
   endproperty
   a_boundary: assert property (p_boundary) else $error("lmfc pulse off boundary");
   property p_shift_f1;
      @(posedge ref_clk) disable iff (rst)
      (octets_ff == 8'h00) |=> shift_ff[1:0] == 2'b00;
   endproperty
   a_shift_f1: assert property (p_shift_f1) else $error("f=1 offset not multiple of four");
   property p_pll_down;
      @(posedge ref_clk) disable iff (rst)
      !link_enable |=> !pll_lock_ff;
   endproperty
   a_pll_down: assert property (p_pll_down) else $error("pll lock while link down");
   property p_dec10;
      @(posedge ref_clk) disable iff (rst)
      (cur_ratio == DEC_RATIO_10) |-> div_cnt_ff <= 4'h9;
   endproperty
   a_dec10: assert property (p_dec10) else $error("divider beyond ratio ten");
   property p_soft_reset;
      @(posedge ref_clk) disable iff (rst)
      soft_reset |=> subclass == 3'h1 && app_mode_ff == APP_FULL_BW && sr_stat_ff == 8'h00;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset defaults wrong");
   // sdo stays enabled after the last read bit until deselect
   property p_sdo_cs;
      @(posedge ref_clk) disable iff (rst)
      !spi_sdo_oe_n |-> !$past(spi_cs_n) && (rd_mode_ff || bit_cnt_ff == 5'h00);
   endproperty
   a_sdo_cs: assert property (p_sdo_cs) else $error("sdo driven outside read");
   property p_app_mode;
      @(posedge ref_clk) disable iff (rst)
      (wr_pulse && wr_addr == ADDR_APP_MODE && wr_data == APP_TWO_DC) |=> two_downconverter;
   endproperty
   a_app_mode: assert property (p_app_mode) else $error("two converter mode not taken");
endmodule
`default_nettype wire

/* design/jls_pkg.sv */
package jls_pkg;
   localparam logic [14:0] ADDR_SOFT_RESET = 15'h0000;
   localparam logic [14:0] ADDR_SYSREF_CTRL = 15'h0120;
   localparam logic [14:0] ADDR_SYSREF_STAT = 15'h0128;
   localparam logic [14:0] ADDR_APP_MODE = 15'h0200;
   localparam logic [14:0] ADDR_CHIP_DEC = 15'h0201;
   localparam logic [14:0] ADDR_DC0_CTRL = 15'h0310;
   localparam logic [14:0] ADDR_DC0_SRC = 15'h0311;
   localparam logic [14:0] ADDR_DC1_CTRL = 15'h0330;
   localparam logic [14:0] ADDR_DC1_SRC = 15'h0331;
   localparam logic [14:0] ADDR_PLL_CTRL = 15'h056e;
   localparam logic [14:0] ADDR_PLL_STAT = 15'h056f;
   localparam logic [14:0] ADDR_LINK_PWR = 15'h0571;
   localparam logic [14:0] ADDR_LMFC_OFS = 15'h0578;
   localparam logic [14:0] ADDR_LANE_CFG = 15'h058b;
   localparam logic [14:0] ADDR_OCTETS = 15'h058c;
   localparam logic [14:0] ADDR_CONV = 15'h058e;
   localparam logic [14:0] ADDR_SUBCLASS = 15'h0590;
   localparam logic [14:0] ADDR_STEP_B = 15'h1222;
   localparam logic [14:0] ADDR_STEP_A = 15'h1228;
   localparam logic [14:0] ADDR_STEP_C = 15'h1262;

   localparam logic [7:0] SOFT_RESET_CMD = 8'h81;
   localparam logic [7:0] APP_FULL_BW = 8'h00;
   localparam logic [7:0] APP_TWO_DC = 8'h02;
   localparam logic [7:0] DEC_CODE_1 = 8'h00;
   localparam logic [7:0] DEC_CODE_10 = 8'h06;
   localparam logic [3:0] DEC_RATIO_1 = 4'h1;
   localparam logic [3:0] DEC_RATIO_10 = 4'ha;
   localparam logic [7:0] RST_SUBCLASS = 8'h20;
   localparam logic [7:0] RST_LINK_PWR = 8'h14;
   localparam logic [7:0] RST_ZERO = 8'h00;

   localparam int SUBCLASS_MSB = 7;
   localparam int SUBCLASS_LSB = 5;
   localparam int OFS_MSB = 4;
   localparam int SR_TRANS_BIT = 4;
   localparam int SR_CLKEDGE_BIT = 3;
   localparam int LANE_SCR_BIT = 7;
   localparam int LANE_CNT_MSB = 4;
   localparam int PWR_DOWN_BIT = 0;
   localparam int PLL_LOCK_BIT = 7;
   localparam int STAT_SETUP_BIT = 0;
   localparam int STAT_HOLD_BIT = 1;
   localparam int DC_GAIN_BIT = 6;
   localparam int DC_SRC_BIT = 0;

   localparam int SPI_INSTR_BITS = 16;
   localparam int SPI_FRAME_BITS = 24;
   localparam int FRAMES_PER_MF = 32;

   localparam int CLK_PERIOD_NS = 20;
   localparam int PLL_LOCK_US = 100;
   localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS;
endpackage

/* tb/jls_link_setup_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module jls_link_setup_tb;
   import jls_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic spi_sclk = 1'b0;
   logic spi_cs_n = 1'b1;
   logic spi_sdi = 1'b0;
   logic sysref = 1'b0;
   logic spi_sdo, spi_sdo_oe_n, lmfc_pulse, sample_strobe, sysref_aligned;
   logic full_bandwidth, two_downconverter, link_enable, scramble_en;
   logic [4:0] lane_count;
   logic [7:0] converter_count, octets_per_frame, pll_select, mf_period;
   logic [2:0] subclass;
   logic dz_gain, dz_src, do_gain, do_src;
   logic [3:0] dz_ratio, do_ratio;
   int num_errors = 0;
   int samples_checked = 0;

   always #10 ref_clk = ~ref_clk;

   jls_link_setup #(.PLL_LOCK_CYCLES(20)) dut (
      .ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n), .sysref(sysref),
      .lmfc_pulse(lmfc_pulse), .sample_strobe(sample_strobe),
      .sysref_aligned(sysref_aligned), .full_bandwidth(full_bandwidth),
      .two_downconverter(two_downconverter), .link_enable(link_enable),
      .scramble_en(scramble_en), .lane_count(lane_count),
      .converter_count(converter_count), .octets_per_frame(octets_per_frame),
      .subclass(subclass), .pll_select(pll_select),
      .downconverter_zero_gain_6db(dz_gain), .downconverter_zero_ratio(dz_ratio),
      .downconverter_zero_src_b(dz_src), .downconverter_one_gain_6db(do_gain),
      .downconverter_one_ratio(do_ratio), .downconverter_one_src_b(do_src)
   );

   jls_rx_model rx (.ref_clk(ref_clk), .rst(rst), .lmfc_pulse(lmfc_pulse),
      .mf_period(mf_period));

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // sclk phases of three ref_clk cycles keep above the two-cycle minimum
   task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat);
      logic [23:0] frame;
      frame = {rd, a, wd};
      rdat = 8'h00;
      @(posedge ref_clk) spi_cs_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge ref_clk) spi_sclk <= 1'b0;
         spi_sdi <= frame[i];
         repeat (2) @(posedge ref_clk);
         @(negedge ref_clk);
         if (i < 8) begin
            rdat = {rdat[6:0], spi_sdo};
            if (rd)
               check("sdo_oe_n", spi_sdo_oe_n, 8'h00);
         end
         @(posedge ref_clk) spi_sclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
      end
      @(posedge ref_clk) spi_sclk <= 1'b0;
      spi_cs_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] unused;
      spi(1'b0, a, d, unused);
   endtask

   task automatic rd_chk(input string what, input logic [14:0] a, input logic [7:0] exp);
      logic [7:0] got;
      spi(1'b1, a, 8'h00, got);
      check(what, got, exp);
   endtask

   task automatic wrc(input logic [14:0] a, input logic [7:0] d);
      wr(a, d);
      rd_chk("readback", a, d);
   endtask

   task automatic strobe_gap(input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      do begin
         @(negedge ref_clk);
         n++;
      end while (sample_strobe !== 1'b1 && n < 8'h40);
      n = 8'h00;
      do begin
         @(negedge ref_clk);
         n++;
      end while (sample_strobe !== 1'b1 && n < 8'h40);
      check("strobe_gap", n, exp);
   endtask

   task automatic quiet(input logic lvl);
      logic hit;
      hit = 1'b0;
      @(posedge ref_clk) sysref <= lvl;
      repeat (16) begin
         @(negedge ref_clk);
         hit = hit | sysref_aligned;
      end
      check("no_align", hit, 8'h00);
   endtask

   // cycles from the alignment pulse to the next multiframe boundary
   task automatic sr_delay(input logic lvl, output logic [7:0] d);
      logic [7:0] n;
      n = 8'h00;
      @(posedge ref_clk) sysref <= lvl;
      do begin
         @(negedge ref_clk);
         n++;
      end while (sysref_aligned !== 1'b1 && n < 8'h10);
      check("aligned", sysref_aligned, 8'h01);
      n = 8'h00;
      do begin
         @(negedge ref_clk);
         n++;
      end while (lmfc_pulse !== 1'b1 && n < 8'h40);
      d = n;
   endtask

   task automatic t_reset;
      check("subclass", subclass, 8'h01);
      check("full_bw", full_bandwidth, 8'h01);
      check("link_en", link_enable, 8'h01);
      rd_chk("subclass_reg", ADDR_SUBCLASS, RST_SUBCLASS);
      rd_chk("link_pwr", ADDR_LINK_PWR, RST_LINK_PWR);
      rd_chk("sr_status", ADDR_SYSREF_STAT, 8'h00);
      rd_chk("unmapped", 15'h0123, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_config;
      logic [14:0] sa[7] = '{ADDR_STEP_A, ADDR_STEP_A, ADDR_STEP_B, ADDR_STEP_B,
                              ADDR_STEP_B, ADDR_STEP_C, ADDR_STEP_C};
      logic [7:0] sd[7] = '{8'h4f, 8'h0f, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00};
      wr(ADDR_SOFT_RESET, SOFT_RESET_CMD);
      // settle span shortened from the millisecond wait to keep the run short
      repeat (20) @(posedge ref_clk);
      rd_chk("soft_rst_reg", ADDR_SOFT_RESET, 8'h00);
      wrc(ADDR_APP_MODE, APP_TWO_DC);
      check("two_dc", two_downconverter, 8'h01);
      check("full_bw", full_bandwidth, 8'h00);
      wrc(ADDR_APP_MODE, APP_FULL_BW);
      check("full_bw", full_bandwidth, 8'h01);
      wrc(ADDR_CHIP_DEC, DEC_CODE_10);
      strobe_gap(8'h0a);
      wrc(ADDR_CHIP_DEC, DEC_CODE_1);
      strobe_gap(8'h01);
      wr(ADDR_LINK_PWR, 8'h15);
      check("link_en", link_enable, 8'h00);
      rd_chk("pll_down", ADDR_PLL_STAT, 8'h00);
      wrc(ADDR_LANE_CFG, 8'h87);
      check("lanes8", {scramble_en, 2'h0, lane_count}, 8'h88);
      wrc(ADDR_LANE_CFG, 8'h81);
      check("lanes2", {scramble_en, 2'h0, lane_count}, 8'h82);
      wrc(ADDR_CONV, 8'h01);
      check("conv2", converter_count, 8'h02);
      wrc(ADDR_CONV, 8'h03);
      check("conv4", converter_count, 8'h04);
      wrc(ADDR_OCTETS, 8'h03);
      check("oct4", octets_per_frame, 8'h04);
      wrc(ADDR_OCTETS, 8'h00);
      check("oct1", octets_per_frame, 8'h01);
      wrc(ADDR_PLL_CTRL, 8'h50);
      check("pll_sel", pll_select, 8'h50);
      wr(ADDR_LINK_PWR, 8'h14);
      check("link_en", link_enable, 8'h01);
      repeat (40) @(posedge ref_clk);
      rd_chk("pll_lock", ADDR_PLL_STAT, 8'h80);
      for (int k = 0; k < 7; k++)
         wrc(sa[k], sd[k]);
      wrc(ADDR_DC0_CTRL, 8'h47);
      wrc(ADDR_DC0_SRC, 8'h20);
      wrc(ADDR_DC1_CTRL, 8'h47);
      wrc(ADDR_DC1_SRC, 8'h25);
      check("dc0", {dz_gain, dz_src, 2'h0, dz_ratio}, 8'h82);
      check("dc1", {do_gain, do_src, 2'h0, do_ratio}, 8'hc2);
      $display("test config done");
   endtask

   task automatic t_sysref;
      logic [7:0] ft[3] = '{8'h00, 8'h01, 8'h03};
      logic [7:0] ot[3] = '{8'he5, 8'h03, 8'h03};
      logic [7:0] st[3] = '{8'h04, 8'h02, 8'h03};
      logic [7:0] d0, d;
      wrc(ADDR_LMFC_OFS, 8'h00);
      sr_delay(1'b1, d0);
      // the model registers the spacing one cycle after the boundary pulse
      @(negedge ref_clk);
      check("mf_period", mf_period, 8'h20);
      quiet(1'b0);
      for (int k = 0; k < 3; k++) begin
         wrc(ADDR_OCTETS, ft[k]);
         wr(ADDR_LMFC_OFS, ot[k]);
         sr_delay(1'b1, d);
         check("lmfc_shift", (d - d0) & 8'h1f, st[k]);
         quiet(1'b0);
      end
      rd_chk("ofs_reg", ADDR_LMFC_OFS, 8'h03);
      wrc(ADDR_SYSREF_CTRL, 8'h10);
      quiet(1'b1);
      sr_delay(1'b0, d);
      wrc(ADDR_SYSREF_CTRL, 8'h18);
      quiet(1'b1);
      sr_delay(1'b0, d);
      rd_chk("sr_hold", ADDR_SYSREF_STAT, 8'h02);
      wr(ADDR_SUBCLASS, 8'hff);
      rd_chk("subclass_reg", ADDR_SUBCLASS, 8'he0);
      wrc(ADDR_SUBCLASS, 8'h00);
      check("subclass0", subclass, 8'h00);
      quiet(1'b1);
      quiet(1'b0);
      wr(ADDR_SOFT_RESET, SOFT_RESET_CMD);
      rd_chk("sr_status", ADDR_SYSREF_STAT, 8'h00);
      check("subclass", subclass, 8'h01);
      $display("test sysref done");
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_config;
      t_sysref;
      end_of_test;
   end

   // about 80 frames of some 150 cycles each are expected
   initial begin
      repeat (60000) @(posedge ref_clk);
      num_errors++;
      $display("watchdog expired");
      end_of_test;
   end
endmodule
`default_nettype wire

/* tb/jls_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module jls_rx_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic lmfc_pulse,
   output logic [7:0] mf_period
);
   logic [7:0] cnt_ff;
   // receive buffer releases on each boundary; the spacing is what it depends on
   always_ff @(posedge ref_clk) begin
      if (rst || lmfc_pulse)
         cnt_ff <= 8'h01;
      else
         cnt_ff <= cnt_ff + 8'h01;
   end
   always_ff @(posedge ref_clk) begin
      if (rst)
         mf_period <= 8'h00;
      else if (lmfc_pulse)
         mf_period <= cnt_ff;
   end
endmodule
`default_nettype wire
